// ### src/pat_pkg.sv
//--------------------------------------------------------------
// Notes on behaviour
//--------------------------------------------------------------
// Notes on behaviour
// - Magnitude within zero band displays zero
// - Analog output follows display value each measuring cycle
// - Source select zero freezes analog output
// - Start/end values are display counts, no point
// - Output type picks 0-20mA, 4-20mA or 0-10V
// - Mode zero: passive, answer host requests only
// - Mode one: send value every measuring cycle
// - Group access limits by user level 0..8
// - Interface/aout to 4, input to 2
// - Odd levels act as next lower even
// - Lock only while codes differ
// - Programming starts at first permitted parameter
// - Matching unlock code plus long key: all groups except level
// - Tier one commissioning only, tier two all
// - Setpoint value refreshed each measuring cycle
// - Sum mode zero holds sum at zero
// - Sum mode one keeps volatile sum
// - Sum mode two saves sum non-volatile
// - Add rate times time over base
// - Sum shown divided by ten power exponent
// - Sum reset by zero write or actuator
`default_nettype none
package pat_pkg;
	//--------------------------------------------------------------
	// Timing
	//--------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10; // 100 MHz core clock
	localparam int KEY_HOLD_MS = 1000; // Programming key hold time
	localparam int KEY_HOLD_CYC = KEY_HOLD_MS * (1000000 / CLK_PERIOD_NS);
	//--------------------------------------------------------------
	// Register byte addresses
	//--------------------------------------------------------------
	localparam logic [7:0] A_ZERO_BAND = 8'h00;
	localparam logic [7:0] A_AOUT_START = 8'h04;
	localparam logic [7:0] A_AOUT_END = 8'h08;
	localparam logic [7:0] A_AOUT_SRC = 8'h0C;
	localparam logic [7:0] A_AOUT_TYPE = 8'h10;
	localparam logic [7:0] A_IFACE_MODE = 8'h14;
	localparam logic [7:0] A_UNLOCK = 8'h18;
	localparam logic [7:0] A_AUTH = 8'h1C;
	localparam logic [7:0] A_LEVEL = 8'h20;
	localparam logic [7:0] A_TIER = 8'h24;
	localparam logic [7:0] A_SUM_MODE = 8'h28;
	localparam logic [7:0] A_SUM_BASE = 8'h2C;
	localparam logic [7:0] A_SUM_EXP = 8'h30;
	localparam logic [7:0] A_SUM_DEC = 8'h34;
	localparam logic [7:0] A_SUM_INIT = 8'h38;
	localparam logic [7:0] A_SUM_RST_SRC = 8'h3C;
	localparam logic [7:0] A_ST_DISP = 8'h40;
	localparam logic [7:0] A_ST_SUM = 8'h44;
	localparam logic [7:0] A_ST_AOUT = 8'h48;
	localparam logic [7:0] A_ST_ACCESS = 8'h4C;
	//--------------------------------------------------------------
	// Reset values
	//--------------------------------------------------------------
	localparam logic [1:0] AOUT_TYPE_RST = 2'h0;
	localparam logic [3:0] LEVEL_RST = 4'h0;
	localparam logic [1:0] TIER_RST = 2'h2; // Professional tier
	localparam logic [15:0] AOUT_INIT = 16'h0000; // Reset code; also the code for output type 3
	localparam logic [15:0] CODE_RST = 16'h0000; // Both codes equal: unlocked
	//--------------------------------------------------------------
	// Access groups, bit positions and highest allowed level
	//--------------------------------------------------------------
	localparam int NGRP = 11;
	localparam int G_BRIGHT = 0;
	localparam int G_LOCK = 1;
	localparam int G_SERIAL = 2;
	localparam int G_THRESH = 3;
	localparam int G_SETPT = 4;
	localparam int G_IFACE = 5;
	localparam int G_AOUT = 6;
	localparam int G_INPUT = 7;
	localparam int G_LIN = 8;
	localparam int G_AUTH = 9;
	localparam int G_LEVEL = 10;
	// Highest level per group; 15 marks a group never open
	localparam logic [3:0] GRP_MAX [NGRP] = '{4'h8, 4'h8, 4'h7, 4'h5, 4'h6, 4'h4,
		4'h4, 4'h2, 4'h2, 4'h0, 4'hF};
	// Lowest parameter number per group
	localparam logic [7:0] GRP_FIRST [NGRP] = '{8'h13, 8'h32, 8'hC8, 8'h3D, 8'h3B,
		8'h20, 8'h14, 8'h00, 8'h64, 8'h33, 8'h34};
	// Commissioning groups seen at the simple tier
	localparam logic [NGRP-1:0] COMMISSION_MASK = 11'h0C3;
	localparam logic [7:0] NO_PARAM = 8'hFF; // Nothing permitted
	//--------------------------------------------------------------
	// Modes
	//--------------------------------------------------------------
	typedef enum logic [1:0] {AT_0_20MA = 2'h0, AT_4_20MA = 2'h1, AT_0_10V = 2'h2} pat_aout_t;
	localparam logic [1:0] SUM_OFF = 2'h0;
	localparam logic [1:0] SUM_VOLATILE = 2'h1;
	localparam logic [1:0] SUM_NONVOL = 2'h2;
	localparam logic [3:0] DIV_MAX = 4'h7; // Largest divisor exponent
	typedef struct packed {
		logic valid; // One-cycle send strobe
		logic [31:0] data; // Display value sent
	} pat_tx_t;
	typedef struct packed {
		logic en; // Output active
		pat_aout_t kind; // Signal range
		logic [15:0] code; // Converter code
	} pat_aout_out_t;
endpackage
`default_nettype wire

// ### src/pat_param_access.sv
// Added by the designer: the placing of the registers and the plain strobed port.
`default_nettype none
module pat_param_access import pat_pkg::*; #(
	parameter int KEY_HOLD = KEY_HOLD_CYC
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Measurement from the front end
	input wire logic meas_cycle,
	input wire logic signed [31:0] meas_value,
	input wire logic [15:0] meas_time_ms,
	// Panel pins
	input wire logic prog_key,
	input wire logic dig_in,
	input wire logic zero_key,
	// Serial side
	input wire logic host_req,
	output pat_tx_t tx,
	// Analog output
	output pat_aout_out_t aout,
	// Display and setpoint values
	output logic signed [31:0] disp_value,
	output logic signed [31:0] setpt_value,
	output logic signed [31:0] sum_disp,
	output logic [3:0] sum_dec,
	// Access control
	output logic [NGRP-1:0] access_mask,
	output logic reduced_opts,
	output logic [7:0] first_param,
	output logic lock_active,
	// Non-volatile sum store
	output logic nv_save,
	output logic signed [63:0] nv_data,
	input wire logic nv_load,
	input wire logic signed [63:0] nv_value
);
	//--------------------------------------------------------------
	// Configuration registers
	//--------------------------------------------------------------
	logic [31:0] band_q; // Zero band amount
	logic signed [31:0] ao_start_q, ao_end_q; // Scale ends, display counts
	logic [7:0] ao_src_q; // Zero disables the output
	logic [1:0] ao_type_q;
	logic iface_mode_q; // 0 passive, 1 cyclic send
	logic [15:0] unlock_q, auth_q; // Committed codes
	logic [15:0] unlock_pend_q, auth_pend_q; // Entered, not yet confirmed
	logic [3:0] level_q;
	logic [1:0] tier_q;
	logic [1:0] sum_mode_q, sum_base_q;
	logic [3:0] sum_exp_q, sum_dec_q;
	logic signed [31:0] sum_init_q;
	logic [1:0] sum_rst_src_q; // 1 input, 2 key, 3 either
	logic sum_zero_wr; // Initial value written as zero

	//--------------------------------------------------------------
	// Register writes
	//--------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			band_q <= 32'h00000000;
			ao_start_q <= 32'sh00000000;
			ao_end_q <= 32'sh00000000;
			ao_src_q <= 8'h00;
			ao_type_q <= AOUT_TYPE_RST;
			iface_mode_q <= 1'b0;
			level_q <= LEVEL_RST;
			tier_q <= TIER_RST;
			sum_mode_q <= SUM_OFF;
			sum_base_q <= 2'h0;
			sum_exp_q <= 4'h0;
			sum_dec_q <= 4'h0;
			sum_init_q <= 32'sh00000000;
			sum_rst_src_q <= 2'h0;
		end else if (reg_wr) begin
			case (reg_addr)
				A_ZERO_BAND: band_q <= reg_wdata;
				A_AOUT_START: ao_start_q <= reg_wdata;
				A_AOUT_END: ao_end_q <= reg_wdata;
				A_AOUT_SRC: ao_src_q <= reg_wdata[7:0];
				A_AOUT_TYPE: ao_type_q <= reg_wdata[1:0];
				A_IFACE_MODE: iface_mode_q <= reg_wdata[0];
				A_LEVEL: level_q <= (reg_wdata[3:0] > 4'h8) ? 4'h8 : reg_wdata[3:0];
				A_TIER: tier_q <= reg_wdata[1:0];
				A_SUM_MODE: sum_mode_q <= reg_wdata[1:0];
				A_SUM_BASE: sum_base_q <= reg_wdata[1:0];
				A_SUM_EXP: sum_exp_q <= (reg_wdata[3:0] > DIV_MAX) ? DIV_MAX : reg_wdata[3:0];
				A_SUM_DEC: sum_dec_q <= reg_wdata[3:0];
				A_SUM_INIT: sum_init_q <= reg_wdata;
				A_SUM_RST_SRC: sum_rst_src_q <= reg_wdata[1:0];
				default: ; // Status and unmapped: ignored
			endcase
		end
	end

	assign sum_zero_wr = reg_wr && (reg_addr == A_SUM_INIT) && (reg_wdata == 32'h00000000);

	//--------------------------------------------------------------
	// Pin synchronisers
	//--------------------------------------------------------------
	logic [2:0] pin_m_q, pin_s_q, pin_d_q; // Key, input, zero key
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_m_q <= 3'h0;
			pin_s_q <= 3'h0;
			pin_d_q <= 3'h0;
		end else begin
			pin_m_q <= {zero_key, dig_in, prog_key};
			pin_s_q <= pin_m_q;
			pin_d_q <= pin_s_q; // Edge detect on settled copy only
		end
	end

	//--------------------------------------------------------------
	// Programming key long press
	//--------------------------------------------------------------
	logic [31:0] hold_q; // Cycles the key has been down
	logic key_long; // One pulse per press
	assign key_long = pin_s_q[0] && (hold_q == 32'(KEY_HOLD - 1));
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_q <= 32'h00000000;
		end else if (!pin_s_q[0]) begin
			hold_q <= 32'h00000000;
		end else if (hold_q != 32'(KEY_HOLD)) begin
			hold_q <= hold_q + 32'h00000001; // Saturates, so one pulse only
		end
	end

	//--------------------------------------------------------------
	// Lock codes: entered codes take effect on a long key press
	//--------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			unlock_pend_q <= CODE_RST;
			auth_pend_q <= CODE_RST;
			unlock_q <= CODE_RST;
			auth_q <= CODE_RST;
		end else begin
			if (reg_wr && reg_addr == A_UNLOCK) begin
				unlock_pend_q <= reg_wdata[15:0];
			end
			if (reg_wr && reg_addr == A_AUTH) begin
				auth_pend_q <= reg_wdata[15:0];
			end
			if (key_long) begin
				unlock_q <= unlock_pend_q;
				auth_q <= auth_pend_q;
			end
		end
	end

	//--------------------------------------------------------------
	// Access mask and first parameter
	//--------------------------------------------------------------
	logic [3:0] eff_level;
	logic [NGRP-1:0] grant;
	assign lock_active = (auth_q != unlock_q);
	// Odd levels drop to the even level below; unlocked means level 0
	assign eff_level = lock_active ? {level_q[3:1], 1'b0} : 4'h0;
	for (genvar g = 0; g < NGRP; g++) begin : g_grant
		assign grant[g] = (GRP_MAX[g] != 4'hF) && (eff_level <= GRP_MAX[g]);
	end
	assign access_mask = (tier_q == 2'h1) ? (grant & COMMISSION_MASK) : grant;
	assign reduced_opts = (tier_q == 2'h1);

	// Lowest permitted parameter number, combinational scan
	always_comb begin
		first_param = NO_PARAM;
		for (int g = 0; g < NGRP; g++) begin
			if (access_mask[g] && GRP_FIRST[g] < first_param) begin
				first_param = GRP_FIRST[g];
			end
		end
	end

	//--------------------------------------------------------------
	// Zero band and setpoint value
	//--------------------------------------------------------------
	logic [31:0] meas_mag;
	logic signed [31:0] disp_d;
	assign meas_mag = meas_value[31] ? 32'(-meas_value) : 32'(meas_value);
	assign disp_d = (meas_mag <= band_q) ? 32'sh00000000 : meas_value;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			disp_value <= 32'sh00000000;
			setpt_value <= 32'sh00000000;
		end else if (meas_cycle) begin
			disp_value <= disp_d;
			setpt_value <= meas_value;
		end
	end

	//--------------------------------------------------------------
	// Analog output scaling
	//--------------------------------------------------------------
	logic signed [63:0] ao_num, ao_den, ao_ratio;
	logic [15:0] ao_calc;
	always_comb begin
		// Start/end are plain counts, same base as the display
		ao_num = 64'(disp_d) - 64'(ao_start_q);
		ao_den = 64'(ao_end_q) - 64'(ao_start_q);
		if (ao_den <= 64'sh0 || ao_num <= 64'sh0) begin
			ao_ratio = 64'sh0;
		end else if (ao_num >= ao_den) begin
			ao_ratio = 64'sh10000;
		end else begin
			ao_ratio = (ao_num * 64'sh10000) / ao_den; // 0..65536 of span
		end
		case (ao_type_q)
			AT_4_20MA: ao_calc = 16'(16'h3333 + ((ao_ratio * 64'shCCCC) >>> 16));
			AT_0_20MA, AT_0_10V: ao_calc = (ao_ratio >= 64'sh10000) ? 16'hFFFF
				: 16'(ao_ratio);
			default: ao_calc = AOUT_INIT;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			aout.code <= AOUT_INIT;
			aout.en <= 1'b0;
			aout.kind <= AT_0_20MA;
		end else begin
			aout.en <= (ao_src_q != 8'h00);
			aout.kind <= pat_aout_t'(ao_type_q);
			if (meas_cycle && ao_src_q != 8'h00) begin
				aout.code <= ao_calc;
			end
		end
	end

	//--------------------------------------------------------------
	// Serial send: cyclic or on request
	//--------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx.valid <= 1'b0;
			tx.data <= 32'h00000000;
		end else begin
			tx.valid <= iface_mode_q ? meas_cycle : host_req;
			if (iface_mode_q ? meas_cycle : host_req) begin
				// Cyclic send takes the value of this cycle, not the stale one
				tx.data <= iface_mode_q ? disp_d : disp_value;
			end
		end
	end

	//--------------------------------------------------------------
	// Totaliser, kept in count-milliseconds
	//--------------------------------------------------------------
	logic signed [63:0] acc_q;
	logic signed [63:0] base_ms, pow10, init_acc;
	logic [1:0] act_rise;
	logic sum_reset;
	assign act_rise = pin_s_q[2:1] & ~pin_d_q[2:1];
	assign sum_reset = sum_zero_wr || |(act_rise & sum_rst_src_q);
	always_comb begin
		case (sum_base_q)
			2'h1: base_ms = 64'sd60000;
			2'h2: base_ms = 64'sd3600000;
			default: base_ms = 64'sd1000;
		endcase
		pow10 = 64'sd1;
		for (int i = 0; i < 7; i++) begin
			if (4'(i) < sum_exp_q) begin
				pow10 = pow10 * 64'sd10;
			end
		end
		init_acc = 64'(sum_init_q) * base_ms;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_q <= 64'sh0; // Volatile content lost at power-up
		end else if (sum_mode_q == SUM_OFF) begin
			acc_q <= 64'sh0;
		end else if (sum_reset) begin
			acc_q <= sum_zero_wr ? 64'sh0 : init_acc;
		end else if (nv_load && sum_mode_q == SUM_NONVOL) begin
			acc_q <= nv_value;
		end else if (meas_cycle) begin
			acc_q <= acc_q + 64'(meas_value) * 64'(meas_time_ms);
		end
	end

	// Save request on each measuring cycle or sum reset in non-volatile mode
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			nv_save <= 1'b0;
			nv_data <= 64'sh0;
			sum_disp <= 32'sh00000000;
			sum_dec <= 4'h0;
		end else begin
			nv_save <= (sum_mode_q == SUM_NONVOL) && (meas_cycle || sum_reset);
			nv_data <= acc_q;
			sum_disp <= 32'((acc_q / base_ms) / pow10);
			sum_dec <= sum_dec_q;
		end
	end

	//--------------------------------------------------------------
	// Register reads, data one cycle later
	//--------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			case (reg_addr)
				A_ZERO_BAND: reg_rdata <= band_q;
				A_AOUT_START: reg_rdata <= ao_start_q;
				A_AOUT_END: reg_rdata <= ao_end_q;
				A_AOUT_SRC: reg_rdata <= {24'h0, ao_src_q};
				A_AOUT_TYPE: reg_rdata <= {30'h0, ao_type_q};
				A_IFACE_MODE: reg_rdata <= {31'h0, iface_mode_q};
				A_UNLOCK: reg_rdata <= {16'h0, unlock_q};
				A_AUTH: reg_rdata <= {16'h0, auth_q};
				A_LEVEL: reg_rdata <= {28'h0, level_q};
				A_TIER: reg_rdata <= {30'h0, tier_q};
				A_SUM_MODE: reg_rdata <= {30'h0, sum_mode_q};
				A_SUM_BASE: reg_rdata <= {30'h0, sum_base_q};
				A_SUM_EXP: reg_rdata <= {28'h0, sum_exp_q};
				A_SUM_DEC: reg_rdata <= {28'h0, sum_dec_q};
				A_SUM_INIT: reg_rdata <= sum_init_q;
				A_SUM_RST_SRC: reg_rdata <= {30'h0, sum_rst_src_q};
				A_ST_DISP: reg_rdata <= disp_value;
				A_ST_SUM: reg_rdata <= sum_disp;
				A_ST_AOUT: reg_rdata <= {15'h0, aout.en, aout.code};
				A_ST_ACCESS: reg_rdata <= {12'h0, lock_active, first_param, access_mask};
				default: reg_rdata <= 32'h00000000; // Unmapped reads zero
			endcase
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

	//--------------------------------------------------------------
	// Assertions
	//--------------------------------------------------------------
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence key_commit_s;
		key_long ##1 1'b1;
	endsequence

	zero_band_a: assert property (meas_cycle && meas_mag <= band_q |=> disp_value == 0)
		else $error("value inside zero band not shown as zero");
	aout_update_a: assert property (meas_cycle && ao_src_q != 0 |=> aout.code == $past(ao_calc))
		else $error("analog output not refreshed");
	aout_frozen_a: assert property (ao_src_q == 0 && aout.en == 0 |=> $stable(aout.code))
		else $error("disabled analog output moved");
	tx_cyclic_a: assert property (iface_mode_q && meas_cycle |=> tx.valid)
		else $error("cyclic send missing");
	tx_passive_a: assert property (!iface_mode_q && !host_req |=> !tx.valid)
		else $error("passive mode sent unasked");
	level_closed_a: assert property (!access_mask[G_LEVEL] && !eff_level[0])
		else $error("level group open or odd level used");
	lock_off_a: assert property (!lock_active && tier_q == 2 |-> access_mask[G_AUTH])
		else $error("unlocked device denies code access");
	key_unlock_a: assert property (key_commit_s |-> unlock_q == $past(unlock_pend_q))
		else $error("unlock code not committed on long press");
	sum_off_a: assert property (sum_mode_q == SUM_OFF |=> acc_q == 0)
		else $error("sum moved in off mode");
	tx_value_a: assert property (iface_mode_q && meas_cycle |=> tx.data == $past(disp_d))
		else $error("cyclic send carried a stale value");
	sum_clear_a: assert property (sum_zero_wr && sum_mode_q != SUM_OFF |=> acc_q == 0)
		else $error("zero write did not clear the sum");
endmodule
`default_nettype wire

// ### verif/pat_panel_host.sv
`default_nettype none
module pat_panel_host #(
	parameter int HOLD = 8
) (
	// Clock
	input wire logic core_clk,
	// Bench commands
	input wire logic press_go,
	input wire logic ask_go,
	// Panel key and bus request
	output logic prog_key,
	output logic host_req
);
	timeunit 1ns;
	timeprecision 1ps;
	int hold_cnt = 0; // Cycles left on the key
	//--------------------------------------------------------------
	// Operator: long press, held past the hold time
	//--------------------------------------------------------------
	always @(posedge core_clk) begin
		if (press_go) begin
			hold_cnt <= HOLD + 4;
		end else if (hold_cnt != 0) begin
			hold_cnt <= hold_cnt - 1;
		end
		prog_key <= press_go || (hold_cnt > 1);
	end
	//--------------------------------------------------------------
	// Host: one-cycle value request, sent in either mode
	//--------------------------------------------------------------
	always @(posedge core_clk) begin
		host_req <= ask_go;
	end
endmodule
`default_nettype wire

// ### verif/pat_param_access_tb.sv
`default_nettype none
module pat_param_access_tb import pat_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	//--------------------------------------------------------------
	// Stimulus and observed signals
	//--------------------------------------------------------------
	localparam int KH = 8; // Short key hold for simulation
	localparam int MAXL [11] = '{8, 8, 7, 5, 6, 4, 4, 2, 2, 0, -1}; // Top level per group
	localparam int PNUM [11] = '{19, 50, 200, 61, 59, 32, 20, 0, 100, 51, 52}; // First number
	logic core_clk = 1'h0;
	logic rst_n = 1'h0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'h0, reg_rd = 1'h0, meas_cycle = 1'h0, dig_in = 1'h0, zero_key = 1'h0;
	logic nv_load = 1'h0, press_go = 1'h0, ask_go = 1'h0;
	logic signed [31:0] meas_value = 32'sh0;
	logic [15:0] meas_time_ms = 16'h03E8; // One second per cycle
	logic signed [63:0] nv_value = 64'sh0;
	logic prog_key, host_req, reduced_opts, lock_active, nv_save;
	logic [31:0] reg_rdata;
	pat_tx_t tx;
	pat_aout_out_t aout;
	logic signed [31:0] disp_value, setpt_value, sum_disp;
	logic [3:0] sum_dec;
	logic [NGRP-1:0] access_mask;
	logic [7:0] first_param;
	logic signed [63:0] nv_data;
	int fails = 0;
	int checked = 0;
	int saves = 0; // Store pulses seen
	pat_param_access #(.KEY_HOLD(KH)) pat_param_access_inst (.core_clk(core_clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .meas_cycle(meas_cycle), .meas_value(meas_value),
		.meas_time_ms(meas_time_ms), .prog_key(prog_key), .dig_in(dig_in), .zero_key(zero_key),
		.host_req(host_req), .tx(tx), .aout(aout), .disp_value(disp_value),
		.setpt_value(setpt_value), .sum_disp(sum_disp), .sum_dec(sum_dec),
		.access_mask(access_mask), .reduced_opts(reduced_opts), .first_param(first_param),
		.lock_active(lock_active), .nv_save(nv_save), .nv_data(nv_data), .nv_load(nv_load),
		.nv_value(nv_value));
	pat_panel_host #(.HOLD(KH)) pat_panel_host_inst (.core_clk(core_clk), .press_go(press_go),
		.ask_go(ask_go), .prog_key(prog_key), .host_req(host_req));
	always #5 core_clk = !core_clk;
	// Count non-volatile store pulses
	always @(posedge core_clk) if (nv_save === 1'h1) saves++;
	//--------------------------------------------------------------
	// Shared tasks
	//--------------------------------------------------------------
	task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'h0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge core_clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'h0;
		#1 cmp(reg_rdata, e);
	endtask
	task automatic meas(input logic signed [31:0] v);
		@(posedge core_clk);
		meas_value <= v;
		meas_cycle <= 1'h1;
		@(posedge core_clk);
		meas_cycle <= 1'h0;
		repeat (3) @(posedge core_clk);
		#1;
	endtask
	// Measuring pulse or host request, then watch for one send
	task automatic send(input logic m, input logic a, input logic ev, input logic [31:0] v);
		logic saw;
		saw = 1'h0;
		@(posedge core_clk);
		meas_value <= v;
		meas_cycle <= m;
		ask_go <= a;
		repeat (4) begin
			@(posedge core_clk);
			meas_cycle <= 1'h0;
			ask_go <= 1'h0;
			#1;
			if (tx.valid === 1'h1) begin
				saw = 1'h1;
				cmp(tx.data, v);
			end
		end
		cmp(saw, ev);
	endtask
	// Long press; wait covers sync and hold
	task automatic press;
		@(posedge core_clk);
		press_go <= 1'h1;
		@(posedge core_clk);
		press_go <= 1'h0;
		repeat (KH + 10) @(posedge core_clk);
		#1;
	endtask
	//--------------------------------------------------------------
	// Scenarios
	//--------------------------------------------------------------
	task automatic t_reset;
		cmp(access_mask, 11'h3FF);
		cmp(first_param, 8'h00);
		cmp(lock_active, 1'h0);
		rd(A_TIER, 32'h2);
		rd(A_AUTH, 32'h0);
		rd(8'h80, 32'h0);
	endtask
	task automatic t_band;
		wr(A_ZERO_BAND, 32'h5);
		meas(32'sh5);
		cmp(disp_value, 32'sh0);
		cmp(setpt_value, 32'sh5);
		meas(-32'sh5);
		cmp(disp_value, 32'sh0);
		meas(-32'sh6);
		cmp(disp_value, -32'sh6);
		rd(A_ST_DISP, 32'hFFFFFFFA);
	endtask
	task automatic t_aout;
		wr(A_AOUT_END, 32'h3E8);
		wr(A_AOUT_SRC, 32'h1);
		for (int k = 0; k < 3; k++) begin
			wr(A_AOUT_TYPE, k);
			meas(32'sh0);
			cmp(aout.kind, k);
			cmp(aout.code, (k == 1) ? 16'h3333 : 16'h0000);
			meas(32'sh3E8);
			cmp(aout.code, 16'hFFFF);
			cmp(aout.en, 1'h1);
		end
		wr(A_AOUT_SRC, 32'h0);
		meas(32'sh0);
		cmp(aout.en, 1'h0);
		cmp(aout.code, 16'hFFFF);
	endtask
	task automatic t_iface;
		wr(A_IFACE_MODE, 32'h0);
		send(1'h1, 1'h0, 1'h0, 32'h32);
		send(1'h0, 1'h1, 1'h1, 32'h32);
		wr(A_IFACE_MODE, 32'h1);
		send(1'h1, 1'h0, 1'h1, 32'h46);
		send(1'h0, 1'h1, 1'h0, 32'h46);
	endtask
	// Each time base gives ten units from one cycle
	task automatic t_sum;
		logic [31:0] rate [3] = '{32'hA, 32'h258, 32'h8CA0};
		wr(A_SUM_EXP, 32'h0);
		wr(A_SUM_MODE, 32'h1);
		wr(A_SUM_DEC, 32'h3);
		for (int b = 0; b < 3; b++) begin
			wr(A_SUM_BASE, b);
			wr(A_SUM_INIT, 32'h0);
			meas(rate[b]);
			cmp(sum_disp, 32'shA);
		end
		wr(A_SUM_EXP, 32'h1);
		meas(32'sh0);
		cmp(sum_disp, 32'sh1);
		cmp(sum_dec, 4'h3);
		cmp(saves, 0);
		wr(A_SUM_EXP, 32'h0);
		wr(A_SUM_INIT, 32'h7);
		wr(A_SUM_RST_SRC, 32'h1);
		dig_in <= 1'h1;
		repeat (5) @(posedge core_clk);
		dig_in <= 1'h0;
		#1 cmp(sum_disp, 32'sh7);
		wr(A_SUM_INIT, 32'h9);
		wr(A_SUM_RST_SRC, 32'h2);
		zero_key <= 1'h1;
		repeat (5) @(posedge core_clk);
		zero_key <= 1'h0;
		#1 cmp(sum_disp, 32'sh9);
		wr(A_SUM_INIT, 32'h0);
		meas(32'sh0);
		cmp(sum_disp, 32'sh0);
		wr(A_SUM_BASE, 32'h0);
		wr(A_SUM_MODE, 32'h2);
		nv_value <= 64'sh4C4B40;
		nv_load <= 1'h1;
		@(posedge core_clk);
		nv_load <= 1'h0;
		meas(32'sh0);
		cmp(sum_disp, 32'sh1388);
		cmp(saves > 0, 1'h1);
		cmp(nv_data, 64'sh4C4B40);
		wr(A_SUM_MODE, 32'h0);
		meas(32'sh64);
		cmp(sum_disp, 32'sh0);
	endtask
	task automatic t_tier;
		wr(A_TIER, 32'h1);
		#1 cmp(access_mask, 11'h0C3);
		cmp(reduced_opts, 1'h1);
		wr(A_TIER, 32'h2);
		#1 cmp(access_mask, 11'h3FF);
	endtask
	task automatic t_lock;
		logic [10:0] m;
		logic [7:0] f;
		wr(A_AUTH, 32'h1234);
		press();
		cmp(lock_active, 1'h1);
		for (int L = 0; L < 9; L++) begin
			wr(A_UNLOCK, 32'h1234);
			press();
			cmp(lock_active, 1'h0);
			cmp(access_mask, 11'h3FF);
			wr(A_LEVEL, L);
			wr(A_UNLOCK, 32'h0);
			press();
			m = 11'h0;
			f = 8'hFF;
			for (int g = 0; g < 11; g++) begin
				if ((L & 14) <= MAXL[g]) begin
					m[g] = 1'h1;
					if (PNUM[g] < f) f = PNUM[g];
				end
			end
			cmp(lock_active, 1'h1);
			cmp(access_mask, m);
			cmp(first_param, f);
		end
	endtask
	//--------------------------------------------------------------
	// Verdict and run control
	//--------------------------------------------------------------
	task automatic print_verdict;
		if (fails == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Run needs about 630 cycles; cut off well beyond that
	initial begin
		#100000;
		fails++;
		print_verdict();
	end
	initial begin
		repeat (5) @(posedge core_clk);
		rst_n <= 1'h1;
		@(posedge core_clk);
		#1 t_reset();
		t_band();
		t_aout();
		t_iface();
		t_sum();
		t_tier();
		t_lock();
		print_verdict();
	end
endmodule
`default_nettype wire
